// ---- verilog/prl_pkg.sv ----
// constants, types and source availability table for the pin output routing block
// assumes one 250 MHz clock (4 ns) and byte-wide register accesses
//
// Notes on behaviour
// R1: every pin has its own output select register
// R2: code zero drives latch; two codes reserved
// R3: each source limited to package-dependent port subset
// R4: direction control keeps governing the output driver
// R5: protocol peripherals may override direction control
// R6: bidirectional signals: input and output same pin
// R7: lock flag clear by default, writes accepted
// R8: lock flag set freezes every routing selection
// R9: set flag only after 0x55 then 0xAA
// R10: clear flag only after same key pair
// R11: no other access during the key sequence (the unit aborts it only on writes elsewhere; reads leave it running)
// R12: one-way: set once per reset, never cleared
// R13: otherwise flag toggles, each change needs keys
// R14: sleep leaves every routing selection unchanged
// R15: power-on/brownout reset loads routing defaults
// R16: other resets keep routing selections intact
// R17: every reset clears the lock flag
// R18: output select is six bits, upper bits zero
// R19: writes to routing registers ignored while locked
// R20: input route: port bits 5:3, pin 2:0
// R21: reserved or unavailable code falls back to latch
`default_nettype none

package prl_pkg;

    // ------------------------------------------------------------
    // widths and addresses
    // ------------------------------------------------------------
    localparam int              ADDR_W         = 16;
    localparam int              DATA_W         = 8;
    localparam int              SEL_W          = 6;
    localparam int              ROUTE_W        = 6;
    localparam int              PORT_W         = 3;
    localparam int              NUM_PORTS      = 5;
    localparam logic [15:0]     OUT_SEL_BASE   = 16'h1d8c;
    localparam logic [15:0]     LOCK_ADDR      = 16'h1e0c;
    localparam logic [15:0]     IN_ROUTE_BASE  = 16'h1e0d;
    localparam logic [15:0]     HOST_CMD_ADDR  = 16'h0000;
    localparam logic [15:0]     HOST_STAT_ADDR = 16'h0001;

    // ------------------------------------------------------------
    // lock keys and timing
    // ------------------------------------------------------------
    localparam logic [7:0]      LOCK_KEY1      = 8'h55;
    localparam logic [7:0]      LOCK_KEY2      = 8'haa;
    localparam int              LOCK_FLAG_BIT  = 0;
    localparam int              SEQ_WINDOW_NS  = 20;
    localparam int              CLK_PERIOD_NS  = 4;
    localparam logic [2:0]      SEQ_WINDOW_CYC = 3'(SEQ_WINDOW_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // source codes and reset values
    // ------------------------------------------------------------
    localparam logic [5:0]      SRC_LATCH      = 6'h00;
    localparam int              IN_ROUTE_CNT   = 6;
    localparam logic [5:0]      IN_ROUTE_RST [IN_ROUTE_CNT] =
        '{6'h08, 6'h04, 6'h10, 6'h0d, 6'h10, 6'h10};
    localparam logic [4:0]      PM_A = 5'h01, PM_B = 5'h02, PM_C = 5'h04;
    localparam logic [4:0]      PM_D = 5'h08, PM_E = 5'h10, PM_ALL = 5'h1f;

    typedef enum {SEQ_IDLE, SEQ_KEY1, SEQ_ARMED} prl_seq_t;
    typedef enum {HS_IDLE, HS_KEY1, HS_KEY2, HS_FLAG} prl_hseq_t;

    // ports {E,D,C,B,A} a source may reach; reserved and unused codes reach none
    function automatic logic [4:0] prl_port_mask(input logic [5:0] code, input logic big);
        logic [4:0] m;
        m = 5'h00;
        case (code)
            6'h00: m = PM_ALL;
            6'h01, 6'h02, 6'h22, 6'h23: m = PM_A | PM_C;
            6'h19, 6'h20: m = big ? (PM_A | PM_D) : (PM_A | PM_C);
            6'h1a: m = big ? (PM_A | PM_E) : (PM_A | PM_C);
            6'h0d, 6'h0e: m = big ? (PM_B | PM_D) : PM_B;
            6'h03, 6'h04, 6'h06, 6'h07, 6'h08, 6'h0f, 6'h10, 6'h16, 6'h18, 6'h1d, 6'h1e:
                m = big ? (PM_B | PM_D) : (PM_B | PM_C);
            6'h05, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h11, 6'h12, 6'h13, 6'h15, 6'h1b, 6'h1c,
            6'h1f, 6'h21:
                m = PM_B | PM_C;
            default: m = 5'h00;
        endcase
        return m;
    endfunction

endpackage

`default_nettype wire

// ---- verilog/prl_if.sv ----
// register link between the routing controller and the routing unit
// assumes both ends share sys_clk; read data stands the cycle after rdStb
`default_nettype none

interface prl_if;
    import prl_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wrStb;
    logic              rdStb;
    logic [DATA_W-1:0] rdata;

    modport dev  (input addr, wdata, wrStb, rdStb, output rdata);
    modport host (output addr, wdata, wrStb, rdStb, input rdata);
endinterface

`default_nettype wire

// ---- verilog/prl_pin_mux.sv ----
// output multiplexer and driver enable for one pin
// assumes the select code is registered by the instantiating unit
`default_nettype none

module prl_pin_mux
    import prl_pkg::*;
#(
    parameter int NUM_SRC = 64
) (
    // selection
    input  wire logic [SEL_W-1:0]   srcSel,
    input  wire logic [PORT_W-1:0]  portIdx,
    input  wire logic               bigPkg,
    // pin own controls
    input  wire logic               latchVal,
    input  wire logic               dirIn,
    // peripheral sources
    input  wire logic [NUM_SRC-1:0] srcVal,
    input  wire logic [NUM_SRC-1:0] ovrEn,
    input  wire logic [NUM_SRC-1:0] ovrVal,
    // pin driver
    output logic                    pinOut,
    output logic                    pinOe
);

    logic [4:0] mask;
    logic       usable;

    always_comb begin
        mask   = prl_port_mask(srcSel, bigPkg);                          // R3
        usable = (portIdx < 3'(NUM_PORTS)) && mask[portIdx];
        pinOut = latchVal;                                               // R2 R21
        pinOe  = !dirIn;                                                 // R4
        if (usable && srcSel != SRC_LATCH) begin
            pinOut = srcVal[srcSel];                                     // R21
            if (ovrEn[srcSel]) begin
                pinOe = ovrVal[srcSel];                                  // R5
            end
        end
    end

endmodule

`default_nettype wire

// ---- verilog/prl_route_unit.sv ----
// routing unit: output select and input route registers, lock flag and key sequence
// assumes reset_n is the power-on/brownout reset and softRst a one-cycle other reset
`default_nettype none

module prl_route_unit
    import prl_pkg::*;
#(
    parameter int   NUM_PINS = 35,
    parameter int   NUM_SRC  = 64,
    parameter logic BIG_PKG  = 1'b1
) (
    // clock and resets
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    input  wire logic                softRst,
    // configuration
    input  wire logic                oneWayCfg,
    // register link
    prl_if.dev                       bus,
    // pin side
    input  wire logic [NUM_PINS-1:0] pinLatch,
    input  wire logic [NUM_PINS-1:0] pinDirCtl,
    input  wire logic [NUM_PINS-1:0] pinIn,
    output logic      [NUM_PINS-1:0] pinOut,
    output logic      [NUM_PINS-1:0] pinOe,
    // peripheral side
    input  wire logic [NUM_SRC-1:0]  srcOut,
    input  wire logic [NUM_SRC-1:0]  srcOeOvrEn,
    input  wire logic [NUM_SRC-1:0]  srcOeOvrVal,
    output logic [IN_ROUTE_CNT-1:0]  periphIn,
    // status
    output logic                     lockFlag
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [SEL_W-1:0]   outSel_q   [NUM_PINS];
    logic [SEL_W-1:0]   outSel_d   [NUM_PINS];
    logic [ROUTE_W-1:0] inRoute_q  [IN_ROUTE_CNT];
    logic [ROUTE_W-1:0] inRoute_d  [IN_ROUTE_CNT];
    logic               lock_q;
    logic               lock_d;
    logic               setOnce_q;
    logic               setOnce_d;
    prl_seq_t           seq_q;
    prl_seq_t           seq_d;
    logic [2:0]         win_q;
    logic [2:0]         win_d;
    logic [DATA_W-1:0]  rdata_q;
    logic [DATA_W-1:0]  rdata_d;
    logic [ADDR_W-1:0]  outIdx;
    logic [ADDR_W-1:0]  inIdx;
    logic               isLock;

    assign outIdx   = bus.addr - OUT_SEL_BASE;
    assign inIdx    = bus.addr - IN_ROUTE_BASE;
    assign isLock   = (bus.addr == LOCK_ADDR);
    assign bus.rdata = rdata_q;
    assign lockFlag = lock_q;

    // ------------------------------------------------------------
    // routing registers
    // ------------------------------------------------------------
    // nothing here looks at sleep: selections simply hold across it       R14
    always_comb begin
        outSel_d  = outSel_q;
        inRoute_d = inRoute_q;
        if (bus.wrStb && !lock_q) begin                                    // R7 R8 R19
            for (int i = 0; i < NUM_PINS; i++) begin
                if (outIdx == 16'(i)) begin
                    outSel_d[i] = bus.wdata[SEL_W-1:0];                    // R1 R18
                end
            end
            for (int i = 0; i < IN_ROUTE_CNT; i++) begin
                if (inIdx == 16'(i)) begin
                    inRoute_d[i] = bus.wdata[ROUTE_W-1:0];
                end
            end
        end
    end

    // only reset_n touches routing; softRst leaves it alone               R15 R16
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            outSel_q  <= '{default: '0};
            inRoute_q <= IN_ROUTE_RST;
        end else begin
            outSel_q  <= outSel_d;
            inRoute_q <= inRoute_d;
        end
    end

    // ------------------------------------------------------------
    // lock flag and key sequence
    // ------------------------------------------------------------
    // any write elsewhere aborts the sequence, so keys split by a stray write cannot arm it; reads elsewhere leave it running
    always_comb begin
        seq_d     = seq_q;
        win_d     = win_q;
        lock_d    = lock_q;
        setOnce_d = setOnce_q;
        if (seq_q == SEQ_ARMED) begin
            win_d = win_q - 3'd1;
            if (win_q == 3'd1) begin
                seq_d = SEQ_IDLE;                                          // R9
            end
        end
        if (bus.wrStb) begin
            if (!isLock) begin
                seq_d = SEQ_IDLE;                                          // R11
            end else begin
                case (seq_q)
                    SEQ_ARMED: begin
                        seq_d = SEQ_IDLE;
                        if (bus.wdata[LOCK_FLAG_BIT] && !lock_q
                            && !(oneWayCfg && setOnce_q)) begin            // R9 R12
                            lock_d    = 1'b1;
                            setOnce_d = 1'b1;
                        end else if (!bus.wdata[LOCK_FLAG_BIT] && lock_q
                                     && !oneWayCfg) begin                  // R10 R12 R13
                            lock_d = 1'b0;
                        end
                    end
                    SEQ_KEY1: begin
                        if (bus.wdata == LOCK_KEY2) begin
                            seq_d = SEQ_ARMED;
                            win_d = SEQ_WINDOW_CYC;
                        end else if (bus.wdata == LOCK_KEY1) begin
                            seq_d = SEQ_KEY1;
                        end else begin
                            seq_d = SEQ_IDLE;
                        end
                    end
                    default: begin
                        seq_d = (bus.wdata == LOCK_KEY1) ? SEQ_KEY1 : SEQ_IDLE;
                    end
                endcase
            end
        end
        if (softRst) begin
            lock_d    = 1'b0;                                              // R17
            setOnce_d = 1'b0;                                              // R12
            seq_d     = SEQ_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_q    <= 1'b0;                                             // R7 R17
            setOnce_q <= 1'b0;
            seq_q     <= SEQ_IDLE;
            win_q     <= 3'd0;
        end else begin
            lock_q    <= lock_d;
            setOnce_q <= setOnce_d;
            seq_q     <= seq_d;
            win_q     <= win_d;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (bus.rdStb) begin
            if (isLock) begin
                rdata_d[LOCK_FLAG_BIT] = lock_q;
            end
            for (int i = 0; i < NUM_PINS; i++) begin
                if (outIdx == 16'(i)) begin
                    rdata_d = {2'b00, outSel_q[i]};                        // R18
                end
            end
            for (int i = 0; i < IN_ROUTE_CNT; i++) begin
                if (inIdx == 16'(i)) begin
                    rdata_d = {2'b00, inRoute_q[i]};
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // input routing
    // ------------------------------------------------------------
    // the route value {port,pin} is the flat pin number; missing pins read low
    always_comb begin
        for (int i = 0; i < IN_ROUTE_CNT; i++) begin
            periphIn[i] = (32'(inRoute_q[i]) < NUM_PINS)
                        ? pinIn[inRoute_q[i]] : 1'b0;                      // R20
        end
    end

    // ------------------------------------------------------------
    // output multiplexers
    // ------------------------------------------------------------
    // combinational from the registered code so a source is not delayed
    for (genvar p = 0; p < NUM_PINS; p++) begin : gPin
        prl_pin_mux #(
            .NUM_SRC (NUM_SRC)
        ) uMux (
            .srcSel   (outSel_q[p]),
            .portIdx  (3'(p / 8)),
            .bigPkg   (BIG_PKG),
            .latchVal (pinLatch[p]),
            .dirIn    (pinDirCtl[p]),
            .srcVal   (srcOut),
            .ovrEn    (srcOeOvrEn),
            .ovrVal   (srcOeOvrVal),
            .pinOut   (pinOut[p]),
            .pinOe    (pinOe[p])
        );
    end

endmodule

`default_nettype wire

// ---- verilog/prl_host.sv ----
// routing controller: forwards software accesses and runs the lock key sequence
// assumes software never makes two accesses in one cycle
`default_nettype none

module prl_host
    import prl_pkg::*;
(
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               reset_n,
    // register link
    prl_if.host                     bus,
    // software port
    input  wire logic [ADDR_W-1:0]  usrAddr,
    input  wire logic [DATA_W-1:0]  usrWdata,
    input  wire logic               usrWrStb,
    input  wire logic               usrRdStb,
    output logic      [DATA_W-1:0]  usrRdData
);

    prl_hseq_t         hs_q;
    prl_hseq_t         hs_d;
    logic              flag_q;
    logic              flag_d;
    logic              refused_q;
    logic              refused_d;
    logic              ownRd_q;
    logic              ownRd_d;
    logic [DATA_W-1:0] stat_q;
    logic [DATA_W-1:0] stat_d;
    logic              busy;
    logic              own;

    assign busy      = (hs_q != HS_IDLE);
    assign own       = (usrAddr == HOST_CMD_ADDR) || (usrAddr == HOST_STAT_ADDR);
    assign usrRdData = ownRd_q ? stat_q : bus.rdata;

    // ------------------------------------------------------------
    // link drive
    // ------------------------------------------------------------
    // the three sequence writes go back to back and nothing is let in between
    always_comb begin
        bus.addr  = usrAddr;
        bus.wdata = usrWdata;
        bus.wrStb = usrWrStb && !own && !busy;
        bus.rdStb = usrRdStb && !own && !busy;                             // R11
        if (busy) begin
            bus.addr  = LOCK_ADDR;
            bus.wrStb = 1'b1;
            case (hs_q)
                HS_KEY1: bus.wdata = LOCK_KEY1;                            // R9 R10
                HS_KEY2: bus.wdata = LOCK_KEY2;
                default: bus.wdata = {7'h00, flag_q};
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencer and status
    // ------------------------------------------------------------
    // software must still give input and output routes the same pin (R6)
    always_comb begin
        hs_d      = hs_q;
        flag_d    = flag_q;
        refused_d = refused_q;
        ownRd_d   = usrRdStb && own && !busy;
        stat_d    = stat_q;
        case (hs_q)
            HS_KEY1: hs_d = HS_KEY2;
            HS_KEY2: hs_d = HS_FLAG;
            HS_FLAG: hs_d = HS_IDLE;
            default: begin
                if (usrWrStb && usrAddr == HOST_CMD_ADDR) begin
                    hs_d   = HS_KEY1;
                    flag_d = usrWdata[LOCK_FLAG_BIT];
                end
            end
        endcase
        if (ownRd_d) begin
            stat_d    = {6'h00, refused_q, busy};
            refused_d = 1'b0;
        end
        // a refusal in the same cycle as the clearing read wins
        if (busy && (usrWrStb || usrRdStb)) begin
            refused_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hs_q      <= HS_IDLE;
            flag_q    <= 1'b0;
            refused_q <= 1'b0;
            ownRd_q   <= 1'b0;
            stat_q    <= 8'h00;
        end else begin
            hs_q      <= hs_d;
            flag_q    <= flag_d;
            refused_q <= refused_d;
            ownRd_q   <= ownRd_d;
            stat_q    <= stat_d;
        end
    end

endmodule

`default_nettype wire

// ---- verif/prl_sva.sv ----
// checks on the register link between routing controller and routing unit
// assumes one clock; tb instantiates it beside the link interface
`default_nettype none

module prl_sva
    import prl_pkg::*;
#(
    parameter int NUM_PINS = 35
) (
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              reset_n,
    // unit controls
    input wire logic              softRst,
    input wire logic              oneWayCfg,
    input wire logic              lockFlag,
    // register link
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wrStb,
    input wire logic              rdStb,
    input wire logic [DATA_W-1:0] rdata
);
    // ----------------
    // helpers
    // ----------------
    logic lockWr;
    logic keyTwo;
    logic selRd;
    logic routeRd;
    assign lockWr  = wrStb && addr == LOCK_ADDR;
    assign keyTwo  = lockWr && wdata == LOCK_KEY2;
    assign selRd   = rdStb && addr >= OUT_SEL_BASE && addr < OUT_SEL_BASE + 16'(NUM_PINS);
    assign routeRd = rdStb && addr >= IN_ROUTE_BASE && addr < IN_ROUTE_BASE + 16'(IN_ROUTE_CNT);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ----------------
    // assertions
    // ----------------
    a_set_needs_wr: assert property ($rose(lockFlag) |-> $past(lockWr && wdata[0]))
        else $error("lock flag set without a lock write");
    a_clr_needs_wr: assert property ($fell(lockFlag) && !$past(softRst) |->
        $past(lockWr && !wdata[0]))
        else $error("lock flag cleared without a lock write");
    // depths 2 to 6 cover every flag write still inside the armed window
    a_keys_first: assert property ($changed(lockFlag) && !$past(softRst) |->
        $past(keyTwo, 2) || $past(keyTwo, 3) || $past(keyTwo, 4) || $past(keyTwo, 5) ||
        $past(keyTwo, 6))
        else $error("lock flag changed without the second key");
    a_soft_unlocks: assert property (softRst |=> !lockFlag)
        else $error("lock flag kept over a soft reset");
    a_one_way_hold: assert property (oneWayCfg && lockFlag && !softRst |=> lockFlag)
        else $error("one way lock was cleared");
    a_lock_readback: assert property (rdStb && addr == LOCK_ADDR |=> rdata[0] == $past(lockFlag))
        else $error("lock register read wrong flag");
    a_sel_six_bits: assert property (selRd |=> rdata[7:6] == 2'b00)
        else $error("output select upper bits not zero");
    a_route_six_bits: assert property (routeRd |=> rdata[7:6] == 2'b00)
        else $error("input route upper bits not zero");
    a_one_access: assert property (!(wrStb && rdStb))
        else $error("two accesses in one cycle");
endmodule

`default_nettype wire

// ---- verif/tb.sv ----
// bench: controller and routing unit joined by the link interface
// assumes the 40-pin source table; reads are checked from a queue
`default_nettype none

module tb
    import prl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NP = 35;
    // port B sources in the 40-pin table, bit per code
    localparam logic [35:0] B_MASK = 36'h2f96ffff8;
    logic            sys_clk = 1'b0;
    logic            reset_n = 1'b0;
    logic            softRst = 1'b0;
    logic            oneWayCfg = 1'b0;
    logic [NP-1:0]   pinLatch = '0, pinDirCtl = '0, pinIn = '0, pinOut, pinOe;
    logic [63:0]     srcOut = '0, srcOeOvrEn = '0, srcOeOvrVal = '0;
    logic [5:0]      periphIn;
    logic            lockFlag;
    logic [15:0]     usrAddr = '0;
    logic [7:0]      usrWdata = '0, usrRdData;
    logic            usrWrStb = 1'b0, usrRdStb = 1'b0, rdPend = 1'b0;
    logic [7:0]      expQ[$];
    int              fail_count = 0, samples_checked = 0;
    int              pins[6] = '{0, 0, 24, 16, 33, 9};
    logic [5:0]      codes[6] = '{6'h09, 6'h14, 6'h0d, 6'h0d, 6'h1a, 6'h24};
    logic            useS[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    always #2 sys_clk = ~sys_clk;

    prl_if u_prl_if();
    prl_host u_prl_host(.sys_clk(sys_clk), .reset_n(reset_n), .bus(u_prl_if.host),
        .usrAddr(usrAddr), .usrWdata(usrWdata), .usrWrStb(usrWrStb), .usrRdStb(usrRdStb),
        .usrRdData(usrRdData));
    prl_route_unit #(.NUM_PINS(NP), .NUM_SRC(64), .BIG_PKG(1'b1)) u_prl_route_unit(
        .sys_clk(sys_clk), .reset_n(reset_n), .softRst(softRst), .oneWayCfg(oneWayCfg),
        .bus(u_prl_if.dev), .pinLatch(pinLatch), .pinDirCtl(pinDirCtl), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .srcOut(srcOut), .srcOeOvrEn(srcOeOvrEn),
        .srcOeOvrVal(srcOeOvrVal), .periphIn(periphIn), .lockFlag(lockFlag));
    prl_sva #(.NUM_PINS(NP)) u_prl_sva(.sys_clk(sys_clk), .reset_n(reset_n),
        .softRst(softRst), .oneWayCfg(oneWayCfg), .lockFlag(lockFlag),
        .addr(u_prl_if.addr), .wdata(u_prl_if.wdata), .wrStb(u_prl_if.wrStb),
        .rdStb(u_prl_if.rdStb), .rdata(u_prl_if.rdata));

    // ----------------
    // reporting
    // ----------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmpByte(input string w, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cmpBit(input string w, input logic e, input logic g);
        cmpByte(w, {7'h00, e}, {7'h00, g});
    endtask

    // ----------------
    // software port
    // ----------------
    // strobes never run back to back, so no signal is assigned twice in a step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        usrAddr <= a;
        usrWdata <= d;
        usrWrStb <= 1'b1;
        @(posedge sys_clk);
        usrWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        usrAddr <= a;
        usrRdStb <= 1'b1;
        expQ.push_back(e);
        @(posedge sys_clk);
        usrRdStb <= 1'b0;
    endtask
    task automatic keys();
        wr(LOCK_ADDR, LOCK_KEY1);
        wr(LOCK_ADDR, LOCK_KEY2);
    endtask
    task automatic waitFlag(input logic e);
        for (int n = 0; n < 12 && lockFlag !== e; n++) begin
            @(negedge sys_clk);
        end
        cmpBit("lockFlag", e, lockFlag);
    endtask
    task automatic pinCase(input int p, input logic [5:0] c, input logic s);
        wr(OUT_SEL_BASE + 16'(p), {2'b11, c});
        @(posedge sys_clk);
        srcOut <= {$urandom, $urandom};
        pinLatch <= NP'({$urandom, $urandom});
        pinDirCtl <= NP'({$urandom, $urandom});
        @(negedge sys_clk);
        cmpBit("pinOut", s ? srcOut[c] : pinLatch[p], pinOut[p]);
        cmpBit("pinOe", !pinDirCtl[p], pinOe[p]);
        rd(OUT_SEL_BASE + 16'(p), {2'b00, c});
    endtask
    task automatic routeCase(input int i, input logic [5:0] r);
        wr(IN_ROUTE_BASE + 16'(i), {2'b10, r});
        rd(IN_ROUTE_BASE + 16'(i), {2'b00, r});
        @(posedge sys_clk);
        pinIn <= NP'({$urandom, $urandom});
        @(negedge sys_clk);
        cmpBit("periphIn", r < NP ? pinIn[r] : 1'b0, periphIn[i]);
    endtask

    always @(negedge sys_clk) begin
        if (rdPend) begin
            if (expQ.size() == 0) begin
                fail_count++;
                $display("mismatch usrRdData expected none seen %h", usrRdData);
            end else begin
                cmpByte("usrRdData", expQ.pop_front(), usrRdData);
            end
        end
        rdPend = usrRdStb;
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        fail_count++;
        $display("mismatch run expected end seen hang");
        finish_test();
    end

    initial begin
        void'($urandom(32'h219776ba));
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(LOCK_ADDR, 8'h00);
        for (int i = 0; i < IN_ROUTE_CNT; i++) rd(IN_ROUTE_BASE + 16'(i), {2'b00, IN_ROUTE_RST[i]});
        for (int p = 0; p < NP; p++) rd(OUT_SEL_BASE + 16'(p), 8'h00);
        for (int i = 0; i < 6; i++) pinCase(pins[i], codes[i], useS[i]);
        for (int c = 63; c >= 0; c--) pinCase(8, 6'(c), c < 36 && B_MASK[c]);
        wr(OUT_SEL_BASE + 16'd8, 8'h1b);
        @(posedge sys_clk);
        srcOeOvrEn <= 64'h800_0000;
        srcOeOvrVal <= {36'h0, pinDirCtl[8], 27'h0};
        @(negedge sys_clk);
        cmpBit("pinOe", pinDirCtl[8], pinOe[8]);
        srcOeOvrEn <= '0;
        routeCase(0, 6'h0a);
        routeCase(1, 6'h08);
        routeCase(2, 6'h27);
        wr(HOST_CMD_ADDR, 8'h01);
        rd(HOST_STAT_ADDR, 8'h00);
        waitFlag(1'b1);
        rd(HOST_STAT_ADDR, 8'h02);
        wr(OUT_SEL_BASE + 16'd8, 8'h05);
        rd(OUT_SEL_BASE + 16'd8, 8'h1b);
        wr(IN_ROUTE_BASE, 8'h00);
        rd(IN_ROUTE_BASE, 8'h0a);
        wr(HOST_CMD_ADDR, 8'h00);
        waitFlag(1'b0);
        wr(LOCK_ADDR, 8'h01);
        rd(LOCK_ADDR, 8'h00);
        keys();
        wr(OUT_SEL_BASE + 16'd1, 8'h00);
        wr(LOCK_ADDR, 8'h01);
        rd(LOCK_ADDR, 8'h00);
        keys();
        rd(LOCK_ADDR, 8'h00);
        wr(LOCK_ADDR, 8'h01);
        rd(LOCK_ADDR, 8'h01);
        keys();
        repeat (8) @(posedge sys_clk);
        wr(LOCK_ADDR, 8'h00);
        rd(LOCK_ADDR, 8'h01);
        keys();
        wr(LOCK_ADDR, 8'h00);
        rd(LOCK_ADDR, 8'h00);
        softRst <= 1'b1;
        @(posedge sys_clk);
        softRst <= 1'b0;
        oneWayCfg <= 1'b1;
        wr(HOST_CMD_ADDR, 8'h01);
        waitFlag(1'b1);
        wr(HOST_CMD_ADDR, 8'h00);
        repeat (6) @(posedge sys_clk);
        keys();
        wr(LOCK_ADDR, 8'h00);
        rd(LOCK_ADDR, 8'h01);
        softRst <= 1'b1;
        @(posedge sys_clk);
        softRst <= 1'b0;
        @(negedge sys_clk);
        cmpBit("lockFlag", 1'b0, lockFlag);
        rd(IN_ROUTE_BASE, 8'h0a);
        wr(HOST_CMD_ADDR, 8'h01);
        waitFlag(1'b1);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        oneWayCfg <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        cmpBit("lockFlag", 1'b0, lockFlag);
        rd(OUT_SEL_BASE + 16'd8, 8'h00);
        rd(IN_ROUTE_BASE, {2'b00, IN_ROUTE_RST[0]});
        repeat (3) @(posedge sys_clk);
        finish_test();
    end
endmodule

`default_nettype wire
